// ==== core/atem_matcher.v ====
// Summary of operation
// - specific mode compares destination port for equality
// - range mode accepts port between lower, upper
// - three port modes; upper bound kept only in range
// - finish flag setting 0, 1 or don't-care
// - synchronize flag setting 0, 1 or don't-care
// - push flag setting 0, 1 or don't-care
// - acknowledge flag setting 0, 1 or don't-care
// - urgent flag setting 0, 1 or don't-care
// - ethertype mode don't-care accepts any frame ethertype except ipv4, arp and ipv6
// - specific ethertype equality, value 0x600 to 0xFFFF except ipv4, arp and ipv6
// - ethertype settings only for ethernet-type class entries
// - at most 512 entries; beyond refused
// - uninstallable entry flagged conflict, readable back
// - flags, ports apply only with matching protocol
`include "atem_consts.vh"

module atem_matcher
#(
   parameter HW_SLOTS = 448            // entries the match hardware can apply
)
(
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // register port
   input  wire [7:0]  regAddr,
   input  wire [31:0] regWdata,
   input  wire        regWrite,
   input  wire        regRead,
   output reg  [31:0] regRdata,
   // frame fields from the ingress parser
   input  wire        frmValid,
   output wire        frmReady,
   input  wire        frmIsTcp,
   input  wire        frmIsUdp,
   input  wire [15:0] frmEtype,
   input  wire [15:0] frmDport,
   input  wire [4:0]  frmTcpFlags,     // fin, syn, psh, ack, urg from bit 0
   // match result to forwarding logic
   output reg         resValid,
   output reg         resHit,
   output reg  [8:0]  resIndex,
   // interrupt
   output wire        irq
);

   localparam S_IDLE = 1'b0;            // waiting for a frame
   localparam S_SCAN = 1'b1;            // walking the entry table

   ////////////////////////////////////////////////////////////////////////////
   // match helpers

   // one tcp flag against its two-bit setting
   function flagOk;
      input [1:0] mode;
      input       bitVal;
      begin
         if (mode == `ATEM_FL_ZERO)
            flagOk = ~bitVal;
         else if (mode == `ATEM_FL_ONE)
            flagOk = bitVal;
         else
            flagOk = 1'b1;              // don't-care
      end
   endfunction

   // codes that belong to ip and arp classes, never to the ethertype class
   function isReservedType;
      input [15:0] et;
      begin
         isReservedType = (et == `ATEM_ET_IPV4) || (et == `ATEM_ET_ARP) ||
                          (et == `ATEM_ET_IPV6);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   reg         state;                   // scan state machine
   reg         ctrlEn;                  // matching enabled
   reg  [9:0]  entryIdx;                // target index for commit and load
   reg  [31:0] stage0;                  // staged entry word, low
   reg  [31:0] stage1;                  // staged entry word, high plus valid
   reg  [3:0]  irqStat;                 // sticky events
   reg  [3:0]  irqMask;                 // event enables
   reg  [511:0] entValid;               // per-entry valid flags
   reg  [8:0]  scanAddr;                // address being read
   reg         scanIssued;              // last address issued
   reg  [8:0]  cmpIdx;                  // index of data now on the read port
   reg         cmpValid;                // read port carries scan data
   reg         loadPend;                // readback waiting for idle
   reg         loadRd;                  // readback data arrives next
   reg  [63:0] rbData;                  // readback entry image
   reg         rbValid;                 // readback valid flag
   reg         lastHit;                 // latest result, hit
   reg  [8:0]  lastIdx;                 // latest result, index
   reg         fTcp;                    // latched frame fields
   reg         fUdp;
   reg  [15:0] fEtype;
   reg  [15:0] fDport;
   reg  [4:0]  fFlags;

   wire [63:0] ramRdata;
   wire [8:0]  ramRdAddr;
   reg         ramWrEn;
   reg  [63:0] ramWdata;
   reg  [3:0]  evtSet;                  // events raised this cycle

   assign frmReady  = (state == S_IDLE);
   assign ramRdAddr = (state == S_SCAN) ? scanAddr : entryIdx[8:0];
   assign irq       = |(irqStat & irqMask);

   ////////////////////////////////////////////////////////////////////////////
   // entry store
   atem_entry_ram u_ram
   (
      .clk    (clk),
      .rst    (rst),
      .wrEn   (ramWrEn),
      .wrAddr (entryIdx[8:0]),
      .wrData (ramWdata),
      .rdAddr (ramRdAddr),
      .rdData (ramRdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // commit decode: checks the staged entry and builds the stored image
   wire        cmdWr     = regWrite && (regAddr == `ATEM_REG_CMD);
   wire        doCommit  = cmdWr && regWdata[`ATEM_CMD_COMMIT];
   wire        doLoad    = cmdWr && regWdata[`ATEM_CMD_LOAD];
   wire [1:0]  sFtype    = stage1[`ATEM_F_FTYPE_LSB-32+1:`ATEM_F_FTYPE_LSB-32];
   wire [1:0]  sDmode    = stage1[`ATEM_F_DMODE_LSB-32+1:`ATEM_F_DMODE_LSB-32];
   wire        sEmode    = stage1[`ATEM_F_EMODE-32];
   wire [15:0] sEtype    = stage1[15:0];
   wire        sValid    = stage1[`ATEM_DATA1_VALID];
   wire        idxFull   = (entryIdx >= `ATEM_ENTRIES);
   wire        badEtype  = sValid && (sFtype == `ATEM_FT_ETYPE) && sEmode &&
                           ((sEtype < `ATEM_ET_MIN) ||
                            isReservedType(sEtype));
   wire        noSlot    = sValid && ({22'h00_0000, entryIdx} >= HW_SLOTS);

   always @*
   begin
      ramWrEn  = doCommit && !idxFull && !badEtype;
      ramWdata = {noSlot, stage1[30:0], stage0};
      // bounds not used by the chosen mode are not kept
      if (sDmode != `ATEM_DP_RANGE)
         ramWdata[`ATEM_F_HI_LSB+15:`ATEM_F_HI_LSB] = 16'h0000;
      if ((sDmode != `ATEM_DP_SPECIFIC) && (sDmode != `ATEM_DP_RANGE))
         ramWdata[`ATEM_F_LO_LSB+15:`ATEM_F_LO_LSB] = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // match of the entry now on the read port against the latched frame
   wire [15:0] eLo    = ramRdata[`ATEM_F_LO_LSB+15:`ATEM_F_LO_LSB];
   wire [15:0] eHi    = ramRdata[`ATEM_F_HI_LSB+15:`ATEM_F_HI_LSB];
   wire [15:0] eEtype = ramRdata[`ATEM_F_ETYPE_LSB+15:`ATEM_F_ETYPE_LSB];
   wire [9:0]  eFlags = ramRdata[`ATEM_F_FLAGS_LSB+9:`ATEM_F_FLAGS_LSB];
   wire [1:0]  eDmode = ramRdata[`ATEM_F_DMODE_LSB+1:`ATEM_F_DMODE_LSB];
   wire [1:0]  eFtype = ramRdata[`ATEM_F_FTYPE_LSB+1:`ATEM_F_FTYPE_LSB];
   wire        eEmode = ramRdata[`ATEM_F_EMODE];
   wire        eConf  = ramRdata[`ATEM_F_CONFLICT];
   reg         portOk;
   wire [4:0]  flagsOk;
   reg         critOk;

   // one comparator per tcp flag
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1)
      begin : g_flag
         assign flagsOk[gi] = flagOk(eFlags[2*gi+1:2*gi], fFlags[gi]);
      end
   endgenerate

   always @*
   begin
      // destination port by mode
      case (eDmode)
         `ATEM_DP_SPECIFIC: portOk = (fDport == eLo);
         `ATEM_DP_RANGE:    portOk = (fDport >= eLo) && (fDport <= eHi);
         default:           portOk = 1'b1;
      endcase
      // criteria by frame-type class, all required together
      case (eFtype)
         `ATEM_FT_ETYPE:
            critOk = !fTcp && !fUdp && !isReservedType(fEtype) &&
                     (!eEmode || (fEtype == eEtype));
         `ATEM_FT_TCP:
            critOk = fTcp && portOk && (&flagsOk);
         `ATEM_FT_UDP:
            critOk = fUdp && portOk;
         default:
            critOk = 1'b1;
      endcase
   end

   // a conflicted entry is stored but never applied
   wire entHit = cmpValid && entValid[cmpIdx] && !eConf && critOk;
   wire scanEnd = cmpValid && (entHit || (cmpIdx == `ATEM_LAST_ENTRY));

   ////////////////////////////////////////////////////////////////////////////
   // scan state machine and result
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state      <= S_IDLE;
         scanAddr   <= 9'h000;
         scanIssued <= 1'b0;
         cmpIdx     <= 9'h000;
         cmpValid   <= 1'b0;
         resValid   <= 1'b0;
         resHit     <= 1'b0;
         resIndex   <= 9'h000;
         fTcp       <= 1'b0;
         fUdp       <= 1'b0;
         fEtype     <= 16'h0000;
         fDport     <= 16'h0000;
         fFlags     <= 5'h00;
      end
      else
      begin
         resValid <= 1'b0;
         case (state)
            S_IDLE:
            begin
               cmpValid <= 1'b0;
               if (frmValid)
               begin
                  fTcp   <= frmIsTcp;
                  fUdp   <= frmIsUdp;
                  fEtype <= frmEtype;
                  fDport <= frmDport;
                  fFlags <= frmTcpFlags;
                  if (ctrlEn)
                  begin
                     state      <= S_SCAN;
                     scanAddr   <= 9'h000;
                     scanIssued <= 1'b0;
                  end
                  else
                  begin
                     // disabled: answer a miss at once
                     resValid <= 1'b1;
                     resHit   <= 1'b0;
                     resIndex <= 9'h000;
                  end
               end
            end
            S_SCAN:
            begin
               // one read per cycle; data lags address by one
               cmpValid <= !scanIssued && !scanEnd;
               cmpIdx   <= scanAddr;
               if (scanAddr == `ATEM_LAST_ENTRY)
                  scanIssued <= 1'b1;
               else
                  scanAddr <= scanAddr + 9'h001;
               if (scanEnd)
               begin
                  // lowest index wins
                  state    <= S_IDLE;
                  resValid <= 1'b1;
                  resHit   <= entHit;
                  resIndex <= cmpIdx;
               end
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers, table maintenance and events
   always @*
   begin
      evtSet = 4'h0;
      evtSet[`ATEM_IRQ_DONE]     = resValid;
      evtSet[`ATEM_IRQ_REJECT]   = doCommit && !idxFull && badEtype;
      evtSet[`ATEM_IRQ_FULL]     = doCommit && idxFull;
      evtSet[`ATEM_IRQ_CONFLICT] = ramWrEn && noSlot;
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrlEn   <= `ATEM_RST_CTRL;
         entryIdx <= 10'h000;
         stage0   <= 32'h0000_0000;
         stage1   <= 32'h0000_0000;
         irqStat  <= 4'h0;
         irqMask  <= `ATEM_RST_MASK;
         entValid <= {512{1'b0}};
         loadPend <= 1'b0;
         loadRd   <= 1'b0;
         rbData   <= 64'h0000_0000_0000_0000;
         rbValid  <= 1'b0;
         lastHit  <= 1'b0;
         lastIdx  <= 9'h000;
      end
      else
      begin
         if (regWrite)
         begin
            case (regAddr)
               `ATEM_REG_CTRL:     ctrlEn   <= regWdata[`ATEM_CTRL_EN];
               `ATEM_REG_INDEX:    entryIdx <= regWdata[9:0];
               `ATEM_REG_DATA0:    stage0   <= regWdata;
               `ATEM_REG_DATA1:    stage1   <= regWdata;
               `ATEM_REG_IRQ_MASK: irqMask  <= regWdata[3:0];
               default:            ;         // others ignored
            endcase
         end
         // write-one-to-clear, a new event wins over the clear
         if (regWrite && (regAddr == `ATEM_REG_IRQ_STAT))
            irqStat <= (irqStat & ~regWdata[3:0]) | evtSet;
         else
            irqStat <= irqStat | evtSet;
         // install or remove an entry
         if (ramWrEn)
            entValid[entryIdx[8:0]] <= sValid;
         // readback waits until the scan frees the read port
         loadRd <= 1'b0;
         if (doLoad && !idxFull)
            loadPend <= 1'b1;
         else if (loadPend && (state == S_IDLE))
         begin
            loadPend <= 1'b0;
            loadRd   <= 1'b1;
         end
         if (loadRd)
         begin
            rbData  <= ramRdata;
            rbValid <= entValid[entryIdx[8:0]];
         end
         if (resValid)
         begin
            lastHit <= resHit;
            lastIdx <= resIndex;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read, data one cycle after the strobe
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         regRdata <= 32'h0000_0000;
      else if (regRead)
      begin
         case (regAddr)
            `ATEM_REG_CTRL:     regRdata <= {31'h0000_0000, ctrlEn};
            `ATEM_REG_INDEX:    regRdata <= {22'h00_0000, entryIdx};
            `ATEM_REG_DATA0:    regRdata <= stage0;
            `ATEM_REG_DATA1:    regRdata <= stage1;
            `ATEM_REG_STATUS:   regRdata <= {29'h0000_0000, loadPend,
                                             rbData[`ATEM_F_CONFLICT],
                                             (state == S_SCAN)};
            `ATEM_REG_IRQ_STAT: regRdata <= {28'h000_0000, irqStat};
            `ATEM_REG_IRQ_MASK: regRdata <= {28'h000_0000, irqMask};
            `ATEM_REG_RESULT:   regRdata <= {lastHit, 22'h00_0000, lastIdx};
            `ATEM_REG_RBK0:     regRdata <= rbData[31:0];
            `ATEM_REG_RBK1:     regRdata <= {rbValid, rbData[62:32]};
            default:            regRdata <= 32'h0000_0000;
         endcase
      end
      else
         regRdata <= 32'h0000_0000;
   end

endmodule // atem_matcher

// ==== core/atem_consts.vh ====
`ifndef ATEM_CONSTS_VH
`define ATEM_CONSTS_VH
// register byte offsets
`define ATEM_REG_CTRL      8'h00
`define ATEM_REG_INDEX     8'h04
`define ATEM_REG_DATA0     8'h08
`define ATEM_REG_DATA1     8'h0C
`define ATEM_REG_CMD       8'h10
`define ATEM_REG_STATUS    8'h14
`define ATEM_REG_IRQ_STAT  8'h18
`define ATEM_REG_IRQ_MASK  8'h1C
`define ATEM_REG_RESULT    8'h20
`define ATEM_REG_RBK0      8'h28
`define ATEM_REG_RBK1      8'h2C
// reset values
`define ATEM_RST_CTRL      1'h0
`define ATEM_RST_MASK      4'h0
// table size
`define ATEM_ENTRIES       10'h200
`define ATEM_LAST_ENTRY    9'h1FF
// control, command and status bit positions
`define ATEM_CTRL_EN       0
`define ATEM_CMD_COMMIT    0
`define ATEM_CMD_LOAD      1
`define ATEM_ST_BUSY       0
`define ATEM_ST_CONFLICT   1
`define ATEM_ST_LOADPEND   2
`define ATEM_DATA1_VALID   31
`define ATEM_RES_HIT       31
// interrupt event bits
`define ATEM_IRQ_DONE      0
`define ATEM_IRQ_REJECT    1
`define ATEM_IRQ_FULL      2
`define ATEM_IRQ_CONFLICT  3
// entry word field positions
`define ATEM_F_LO_LSB      0
`define ATEM_F_HI_LSB      16
`define ATEM_F_ETYPE_LSB   32
`define ATEM_F_FLAGS_LSB   48
`define ATEM_F_DMODE_LSB   58
`define ATEM_F_FTYPE_LSB   60
`define ATEM_F_EMODE       62
`define ATEM_F_CONFLICT    63
// frame-type selector codes
`define ATEM_FT_ANY        2'h0
`define ATEM_FT_ETYPE      2'h1
`define ATEM_FT_TCP        2'h2
`define ATEM_FT_UDP        2'h3
// destination-port modes
`define ATEM_DP_ANY        2'h0
`define ATEM_DP_SPECIFIC   2'h1
`define ATEM_DP_RANGE      2'h2
// flag settings
`define ATEM_FL_ZERO       2'h0
`define ATEM_FL_ONE        2'h1
// ethertype limits and reserved codes
`define ATEM_ET_MIN        16'h0600
`define ATEM_ET_IPV4       16'h0800
`define ATEM_ET_ARP        16'h0806
`define ATEM_ET_IPV6       16'h86DD
`endif

// ==== core/atem_entry_ram.v ====
// entry store: one write port, one read port, registered read data
module atem_entry_ram
(
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // write port
   input  wire        wrEn,
   input  wire [8:0]  wrAddr,
   input  wire [63:0] wrData,
   // read port
   input  wire [8:0]  rdAddr,
   output reg  [63:0] rdData
);

   reg [63:0] mem [0:511];   // no reset: validity lives in flops outside

   ////////////////////////////////////////////////////////////////////////////
   // write side
   always @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read side, one cycle latency
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdData <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         rdData <= mem[rdAddr];
      end
   end

endmodule // atem_entry_ram

// ==== verif/atem_matcher_checker.sv ====
// timing relations at the matcher ports, seen from outside only
`include "atem_consts.vh"

module atem_matcher_checker
#(
   parameter HW_SLOTS = 448               // entries the hardware can apply
)
(
   // clock and reset
   input wire        clk,
   input wire        rst,
   // register port
   input wire [7:0]  regAddr,
   input wire [31:0] regWdata,
   input wire        regWrite,
   input wire        regRead,
   input wire [31:0] regRdata,
   // frame handshake and result
   input wire        frmValid,
   input wire        frmReady,
   input wire        resValid,
   input wire        resHit,
   input wire [8:0]  resIndex,
   input wire        irq
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   reg [9:0] sinceTake;                   // cycles since the last taken frame

   // saturating count, so a long idle spell cannot wrap into a false match
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         sinceTake <= 10'h000;
      else if (frmValid && frmReady)
         sinceTake <= 10'h001;
      else if (sinceTake != 10'h3FF)
         sinceTake <= sinceTake + 10'h001;
   end

   ////////////////////////////////////////////////////////////////////////
   a_rdata_quiet: assert property (!$past(regRead) |-> regRdata == 32'h0000_0000)
      else $error("stray read data");
   a_frame_answered: assert property (frmValid && frmReady |-> ##[1:514] resValid)
      else $error("frame not answered");
   a_busy_after_take: assert property (frmValid && frmReady |=> !frmReady || resValid)
      else $error("ready during scan");
   a_ready_at_result: assert property (resValid |-> frmReady)
      else $error("result while busy");
   a_hit_installable: assert property (resValid && resHit |-> resIndex < HW_SLOTS)
      else $error("hit beyond slots");
   a_result_holds: assert property (!resValid |-> $stable(resHit) && $stable(resIndex))
      else $error("result changed unpulsed");
   a_mask_silences: assert property (regWrite && regAddr == `ATEM_REG_IRQ_MASK &&
      regWdata[3:0] == 4'h0 |=> !irq)
      else $error("irq while masked");
   a_hit_latency: assert property (resValid && resHit |->
      sinceTake == {1'b0, resIndex} + 10'h003)
      else $error("hit latency");
   a_miss_latency: assert property (resValid && !resHit |->
      sinceTake == 10'h202 || sinceTake == 10'h001)
      else $error("miss latency");
endmodule // atem_matcher_checker

// ==== verif/atem_parser_model.sv ====
// ingress parser stand-in: offers one frame's fields, holds them until taken
module atem_parser_model
(
   // clock
   input  wire        clk,
   // handshake
   input  wire        frmReady,
   output logic       frmValid,
   // frame fields
   output logic       frmIsTcp,
   output logic       frmIsUdp,
   output logic [15:0] frmEtype,
   output logic [15:0] frmDport,
   output logic [4:0] frmTcpFlags
);
   timeunit 1ns;
   timeprecision 1ps;

   // junk while idle exposes reads of invalid fields
   initial
   begin
      frmValid = 1'b0;
      {frmIsTcp, frmIsUdp, frmEtype, frmDport, frmTcpFlags} = 39'h55_5555_5555;
   end

   // waits gap + 1 edges before offering
   task automatic send(input logic tcp, input logic udp, input logic [15:0] et,
                       input logic [15:0] dp, input logic [4:0] fl, input int gap);
      int guard;
      begin
         guard = 0;
         repeat (gap + 1) @(posedge clk);
         frmValid    <= 1'b1;
         frmIsTcp    <= tcp;
         frmIsUdp    <= udp;
         frmEtype    <= et;
         frmDport    <= dp;
         frmTcpFlags <= fl;
         @(posedge clk);
         while (frmReady !== 1'b1 && guard < 700)
         begin
            @(posedge clk);
            guard++;
         end
         // released fields show the inverse, never the last value
         frmValid <= 1'b0;
         {frmIsTcp, frmIsUdp, frmEtype, frmDport, frmTcpFlags} <= ~{tcp, udp, et, dp, fl};
      end
   endtask
endmodule // atem_parser_model

// ==== verif/tb.sv ====
`include "atem_consts.vh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int SLOTS = 448;            // installable entries
   // clock, reset, register port
   logic        clk;
   logic        rst;
   logic [7:0]  regAddr;
   logic [31:0] regWdata;
   logic        regWrite;
   logic        regRead;
   wire  [31:0] regRdata;
   // frame side
   wire         frmValid, frmReady, frmIsTcp, frmIsUdp, resValid, resHit, irq;
   wire  [15:0] frmEtype, frmDport;
   wire  [4:0]  frmTcpFlags;
   wire  [8:0]  resIndex;
   // scoreboard
   int          n_mismatch, tests_run, seed, i, v;
   logic [9:0]  resQ[$];                  // expected {hit, index}
   logic [31:0] rdQ[$];                   // expected read data
   logic        rdPend;
   logic [15:0] pA, ports[5];
   logic [9:0]  hits[5];
   logic [4:0]  fr;

   atem_matcher #(.HW_SLOTS(SLOTS)) atem_matcher_i (.clk, .rst, .regAddr, .regWdata,
      .regWrite, .regRead, .regRdata, .frmValid, .frmReady, .frmIsTcp, .frmIsUdp,
      .frmEtype, .frmDport, .frmTcpFlags, .resValid, .resHit, .resIndex, .irq);
   atem_parser_model atem_parser_model_i (.clk, .frmReady, .frmValid, .frmIsTcp,
      .frmIsUdp, .frmEtype, .frmDport, .frmTcpFlags);

   always #2.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // read answers come one cycle after the strobe; results whenever they pulse
   always @(posedge clk)
   begin
      if (rdPend)
         check(regRdata, rdQ.pop_front());
      rdPend <= regRead;
      if (resValid === 1'b1 && resQ.size() == 0)
      begin
         n_mismatch++;
         $display("[FAIL] %0t result with none expected", $time);
      end
      else if (resValid === 1'b1)
      begin
         hits[0] = resQ.pop_front();
         check({22'h0, resHit, hits[0][9] ? resIndex : 9'h000}, {22'h0, hits[0]});
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      rdQ.push_back(exp);
      @(posedge clk);
      regRead <= 1'b0;
   endtask

   task automatic commit(input logic [9:0] idx, input logic [31:0] d0, input logic [31:0] d1);
      wr(`ATEM_REG_INDEX, {22'h0, idx});
      wr(`ATEM_REG_DATA0, d0);
      wr(`ATEM_REG_DATA1, d1);
      wr(`ATEM_REG_CMD, 32'h0000_0001);
   endtask

   task automatic load(input logic [9:0] idx);
      wr(`ATEM_REG_INDEX, {22'h0, idx});
      wr(`ATEM_REG_CMD, 32'h0000_0002);
      repeat (3) @(posedge clk);
   endtask

   // offer a frame with a random gap, then wait for its result to be checked
   task automatic frame(input logic t, input logic u, input logic [15:0] et,
                        input logic [15:0] dp, input logic [4:0] fl, input logic [9:0] exp);
      int guard;
      guard = 0;
      resQ.push_back(exp);
      atem_parser_model_i.send(t, u, et, dp, fl, $unsigned($random(seed)) % 3);
      while (resQ.size() != 0 && guard < 700)
      begin
         @(posedge clk);
         guard++;
      end
   endtask

   function automatic logic [31:0] ent(input logic [1:0] ft, input logic [1:0] dm,
                                       input logic [9:0] fl, input logic em,
                                       input logic [15:0] et);
      return {1'b1, em, ft, dm, fl, et};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(5ns * 40000);
      n_mismatch++;
      summarize();
   end

   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      {regAddr, regWdata, regWrite, regRead, rdPend} = '0;
      {n_mismatch, tests_run, seed} = {32'd0, 32'd0, 32'd93};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(`ATEM_REG_CTRL, {31'h0, `ATEM_RST_CTRL});
      rd(`ATEM_REG_IRQ_MASK, {28'h0, `ATEM_RST_MASK});
      rd(8'h40, 32'h0000_0000);
      frame(1'b1, 1'b0, 16'h0800, 16'h0050, 5'h00, 10'h000);
      wr(`ATEM_REG_IRQ_MASK, 32'h0000_000F);
      wr(`ATEM_REG_IRQ_STAT, 32'h0000_000F);
      rd(`ATEM_REG_IRQ_STAT, 32'h0000_0000);
      commit(`ATEM_ENTRIES, 32'h0000_0000, ent(`ATEM_FT_ANY, 2'h0, 10'h3FF, 1'b0, 16'h0));
      rd(`ATEM_REG_IRQ_STAT, 32'h0000_0004);
      ports[0] = `ATEM_ET_IPV4;
      ports[1] = `ATEM_ET_ARP;
      ports[2] = `ATEM_ET_IPV6;
      ports[3] = 16'h05FF;
      for (i = 0; i < 4; i++)
      begin
         wr(`ATEM_REG_IRQ_STAT, 32'h0000_000F);
         commit(10'h003, 32'h0, ent(`ATEM_FT_ETYPE, 2'h0, 10'h3FF, 1'b1, ports[i]));
         rd(`ATEM_REG_IRQ_STAT, 32'h0000_0002);
      end
      wr(`ATEM_REG_IRQ_STAT, 32'h0000_000F);
      commit(10'd448, 32'h0, ent(`ATEM_FT_ANY, 2'h0, 10'h3FF, 1'b0, 16'h0));
      rd(`ATEM_REG_IRQ_STAT, 32'h0000_0008);
      load(10'd448);
      rd(`ATEM_REG_STATUS, 32'h0000_0002);
      #1 check({31'h0, irq}, 32'h1);
      wr(`ATEM_REG_IRQ_MASK, 32'h0000_0000);
      #1 check({31'h0, irq}, 32'h0);
      wr(`ATEM_REG_IRQ_MASK, 32'h0000_000F);
      wr(`ATEM_REG_IRQ_STAT, 32'h0000_000F);
      #1 check({31'h0, irq}, 32'h0);
      // enabled: ports above 0x7FFF keep the tcp port clear of the udp range
      wr(`ATEM_REG_CTRL, 32'h0000_0001);
      pA = {1'b1, 15'($random(seed))};
      commit(10'h001, {16'd2000, 16'd1000}, ent(`ATEM_FT_UDP, `ATEM_DP_RANGE, 10'h3FF, 1'b0, 16'h0));
      commit(10'h002, 32'h0, ent(`ATEM_FT_ETYPE, 2'h0, 10'h3FF, 1'b1, 16'h88B5));
      for (i = 0; i < 10; i++)
      begin
         v = i % 2;
         fr = 5'($random(seed));
         hits[1] = 10'h3FF;
         hits[1][2 * (i / 2) +: 2] = {1'b0, v[0]};
         commit(10'h000, {16'hFFFF, pA}, ent(`ATEM_FT_TCP, `ATEM_DP_SPECIFIC, hits[1], 1'b0, 16'h0));
         fr[i / 2] = v[0];
         frame(1'b1, 1'b0, 16'h0800, pA, fr, 10'h200);
         fr[i / 2] = ~v[0];
         frame(1'b1, 1'b0, 16'h0800, pA, fr, 10'h000);
      end
      frame(1'b1, 1'b0, 16'h0800, pA + 16'h1, 5'h10, 10'h000);
      frame(1'b0, 1'b1, 16'h0800, pA, 5'h10, 10'h000);
      load(10'h000);
      rd(`ATEM_REG_RBK0, {16'h0000, pA});
      ports = '{16'd1000, 16'd2000, 16'd999, 16'd2001, 16'd1000 + 16'($unsigned($random(seed)) % 1001)};
      hits = '{10'h201, 10'h201, 10'h000, 10'h000, 10'h201};
      for (i = 0; i < 5; i++)
         frame(1'b0, 1'b1, 16'h0800, ports[i], 5'h00, hits[i]);
      frame(1'b1, 1'b0, 16'h0800, 16'd1500, 5'h00, 10'h000);
      load(10'h001);
      rd(`ATEM_REG_RBK0, {16'd2000, 16'd1000});
      frame(1'b0, 1'b0, 16'h88B5, 16'h0005, 5'h00, 10'h202);
      frame(1'b0, 1'b0, 16'h88B6, 16'h0005, 5'h00, 10'h000);
      frame(1'b1, 1'b0, 16'h88B5, 16'h0005, 5'h00, 10'h000);
      commit(10'h002, 32'h0, ent(`ATEM_FT_ETYPE, 2'h0, 10'h3FF, 1'b0, 16'h88B5));
      frame(1'b0, 1'b0, 16'h1234, 16'h0005, 5'h00, 10'h202);
      frame(1'b0, 1'b0, `ATEM_ET_ARP, 16'h0005, 5'h00, 10'h000);
      commit(10'd447, 32'h0, ent(`ATEM_FT_ANY, 2'h0, 10'h3FF, 1'b0, 16'h0));
      frame(1'b0, 1'b1, 16'h0800, 16'h0003, 5'h00, {1'b1, 9'd447});
      rd(`ATEM_REG_RESULT, {1'b1, 22'h0, 9'd447});
      summarize();
   end
endmodule // tb

bind atem_matcher atem_matcher_checker #(.HW_SLOTS(HW_SLOTS)) atem_matcher_checker_i (
   .clk, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .frmValid,
   .frmReady, .resValid, .resHit, .resIndex, .irq);
